// file: logic/swx_pkg.sv
// Package of constants for the single-wire output expander link
// ==========================================================================
// What this block does
// - Master keeps bit time constant per burst
// - Bit time 1 us to 10 ms accepted
// - Falling edge on idle line starts burst
// - Time high sync slot from its rising edge to the next falling edge
// - Sample five data slots mid-bit, MSB first
// - Load all outputs together after last bit
// - Master returns line high after last slot
// - Master times slots from its own clock
// - Five driven outputs set by serial line
package swx_pkg;
  // ========================================================================
  // Timing
  localparam int CLK_HZ       = 25000000;
  localparam int BIT_MIN_NS   = 1000;      // Shortest bit time
  localparam int BIT_MAX_US   = 10000;     // Longest bit time
  localparam int BIT_MIN_CYC  = (BIT_MIN_NS * (CLK_HZ / 1000000)
                                 + 999) / 1000;
  localparam int BIT_MAX_CYC  = BIT_MAX_US * (CLK_HZ / 1000000);
  localparam int CNT_W        = 20;        // Holds two longest bit times
  localparam int DATA_W       = 5;
  localparam int SYNC_SLOTS   = 2;
endpackage

// file: logic/swx_link_if.sv
// Interface carrying the single serial data wire between the two ends
`timescale 1ns/1ps
interface swx_link_if;
  logic serial_data;  // Idle high, driven push-pull by the master
  modport master (output serial_data);
  modport receiver (input serial_data);
endinterface

// file: logic/swx_receiver.sv
// Receiver end: decodes bursts and drives five parallel outputs
`timescale 1ns/1ps
module swx_receiver #(
  parameter int CNT_W = swx_pkg::CNT_W
) (
  // Clock and reset
  input  wire logic                       i_core_clk,
  input  wire logic                       i_rst_b,
  // Serial link
  swx_link_if.receiver                    link,
  // Parallel outputs
  output logic [swx_pkg::DATA_W-1:0]      o_parallel_out,
  output logic                            o_burst_done
);
  // ========================================================================
  // How a burst is decoded
  //
  // The line idles high. A burst is a low start slot, a high first sync
  // slot, a low second sync slot and five data slots, first bit first,
  // every slot one bit time long.
  //
  // The second sync slot is low, so the rising edge that would close it
  // only exists when the first data bit is a one. The falling edge that
  // splits the two sync slots is always there, so the high slot is timed
  // from its rising edge up to that fall. That count is one bit time,
  // which is half of the two-slot sync interval.
  //
  // The timer is restarted at the sync fall. The first sample waits one
  // and a half bit times, which lands it mid first data slot; each later
  // sample follows one bit time after the one before. Because the timer
  // restarts at every sample point, rounding of the half bit is paid
  // once and does not pile up across the five slots.
  //
  // The outputs move together on the edge that takes the last sample and
  // hold their value until the next complete burst. A burst cut short by
  // a sync slot longer than the timer can hold is dropped without
  // touching the outputs.

  // ========================================================================
  // Sequencer states, one-hot
  typedef enum logic [4:0] {
    SWX_IDLE  = 5'h01,  // Line idle, waiting for a start edge
    SWX_START = 5'h02,  // Inside the low start slot
    SWX_SYNC  = 5'h04,  // Timing the high first sync slot
    SWX_DATA  = 5'h08,  // Sampling the five data slots
    SWX_END   = 5'h10   // Waiting for the line to return high
  } swx_rx_state_t;

  swx_rx_state_t              state;
  swx_rx_state_t              next_state;
  logic                       line_q;
  logic [CNT_W-1:0]           timer;
  logic [CNT_W-1:0]           bit_cyc;
  logic [CNT_W-1:0]           thr;
  logic [2:0]                 bit_idx;
  logic [swx_pkg::DATA_W-1:0] shreg;
  logic                       rise;
  logic                       fall;
  logic                       sync_end;
  logic                       sync_ovf;
  logic                       sample_now;
  logic                       last_bit;

  // ========================================================================
  // Edge detection on the line
  assign rise = link.serial_data & ~line_q;
  assign fall = ~link.serial_data & line_q;

  // Previous line level; resets to the idle level so no false edge
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      line_q <= 1'b1;
    end else begin
      line_q <= link.serial_data;
    end
  end

  // ========================================================================
  // Control decodes
  // End of the high sync slot: its length is one bit time
  assign sync_end   = (state == SWX_SYNC) && fall;
  // Sync slot too long for the timer: give the burst up
  assign sync_ovf   = (state == SWX_SYNC) && (timer == '1);
  // One and a half bit times to the first sample, then one bit time
  assign thr        = (bit_idx == 3'h0) ?
                      bit_cyc + (bit_cyc >> 1) : bit_cyc;
  assign sample_now = (state == SWX_DATA) && (timer >= thr);
  assign last_bit   = (bit_idx == 3'(swx_pkg::DATA_W - 1));

  // ========================================================================
  // Burst sequencer, next state
  always_comb begin
    next_state = state;
    unique case (state)
      SWX_IDLE: begin
        if (fall) begin
          next_state = SWX_START;
        end
      end
      SWX_START: begin
        if (rise) begin
          next_state = SWX_SYNC;
        end
      end
      SWX_SYNC: begin
        if (sync_end) begin
          next_state = SWX_DATA;
        end else if (sync_ovf) begin
          next_state = SWX_IDLE;  // Interval out of range
        end
      end
      SWX_DATA: begin
        if (sample_now && last_bit) begin
          next_state = SWX_END;
        end
      end
      SWX_END: begin
        // Wait for line high before a new start can be seen
        if (link.serial_data) begin
          next_state = SWX_IDLE;
        end
      end
    endcase
  end

  // State register
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state <= SWX_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // ========================================================================
  // Slot timer: restarts at the sync rise, the sync fall and each sample
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      timer <= '0;
    end else if ((state == SWX_START && rise) || sync_end || sample_now) begin
      timer <= CNT_W'(1);
    end else if (state == SWX_SYNC || state == SWX_DATA) begin
      timer <= timer + CNT_W'(1);
    end
  end

  // Measured bit time in clock cycles, kept for the whole burst
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      bit_cyc <= '0;
    end else if (sync_end) begin
      bit_cyc <= timer;
    end
  end

  // Index of the data slot being sampled
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      bit_idx <= 3'h0;
    end else if (sync_end) begin
      bit_idx <= 3'h0;
    end else if (sample_now) begin
      bit_idx <= bit_idx + 3'h1;
    end
  end

  // Sample shift register, first bit enters at the bottom and moves up
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      shreg <= '0;
    end else if (sample_now) begin
      shreg <= {shreg[swx_pkg::DATA_W-2:0], link.serial_data};
    end
  end

  // ========================================================================
  // Output register, loaded once per complete burst
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_parallel_out <= '0;
      o_burst_done   <= 1'b0;
    end else begin
      o_burst_done <= 1'b0;
      if (sample_now && last_bit) begin
        // First bit lands in the top output
        o_parallel_out <= {shreg[swx_pkg::DATA_W-2:0],
                           link.serial_data};
        o_burst_done   <= 1'b1;
      end
    end
  end
endmodule

// file: logic/swx_master.sv
// Master end: sends one burst of five bits on request
`timescale 1ns/1ps
module swx_master #(
  parameter int CNT_W = swx_pkg::CNT_W
) (
  // Clock and reset
  input  wire logic                       i_core_clk,
  input  wire logic                       i_rst_b,
  // Request
  input  wire logic                       i_send,
  input  wire logic [swx_pkg::DATA_W-1:0] i_data,
  input  wire logic [CNT_W-1:0]           i_bit_cyc,
  output logic                            o_busy,
  // Serial link
  swx_link_if.master                      link
);
  logic [CNT_W-1:0] div;
  logic [3:0]       slot;
  logic [7:0]       frame;
  logic [CNT_W-1:0] bit_cyc;
  logic             tick;

  // Slot enable pulse from the divider; bit time fixed per burst
  assign tick = o_busy && (div == bit_cyc - CNT_W'(1));

  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      div <= '0;
    end else begin
      div <= (tick || !o_busy) ? '0 : div + CNT_W'(1);
    end
  end

  // Burst sequencing: start, two sync slots, five data slots
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_busy           <= 1'b0;
      slot             <= 4'h0;
      frame            <= 8'hff;
      bit_cyc          <= CNT_W'(swx_pkg::BIT_MIN_CYC);
      link.serial_data <= 1'b1;
    end else if (!o_busy) begin
      link.serial_data <= 1'b1;
      if (i_send) begin
        // Clamp bit time into the legal range
        bit_cyc <= (i_bit_cyc < CNT_W'(swx_pkg::BIT_MIN_CYC)) ?
                   CNT_W'(swx_pkg::BIT_MIN_CYC) :
                   (i_bit_cyc > CNT_W'(swx_pkg::BIT_MAX_CYC)) ?
                   CNT_W'(swx_pkg::BIT_MAX_CYC) : i_bit_cyc;
        frame            <= {2'b10, i_data, 1'b1};
        link.serial_data <= 1'b0;
        o_busy           <= 1'b1;
        slot             <= 4'h0;
      end
    end else if (tick) begin
      if (slot == 4'h7) begin
        link.serial_data <= 1'b1;
        o_busy           <= 1'b0;
      end else begin
        link.serial_data <= frame[7];
        frame            <= {frame[6:0], 1'b1};
        slot             <= slot + 4'h1;
      end
    end
  end
endmodule

// file: dv/swx_properties.sv
// Checker of wire and output timing on the single-wire link
`timescale 1ns/1ps
module swx_properties (
  // Clock, reset and watched signals
  input wire logic                       i_core_clk,
  input wire logic                       i_rst_b,
  input wire logic                       serial_data,
  input wire logic                       o_busy,
  input wire logic                       o_burst_done,
  input wire logic [swx_pkg::DATA_W-1:0] o_parallel_out
);
  // ======================================================================
  // Properties
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_b);
  AST_IDLE_HIGH: assert property (!o_busy |-> serial_data)
    else $error("line low while idle");
  AST_FALL_BUSY: assert property ($fell(serial_data) |-> o_busy)
    else $error("fall outside burst");
  AST_SLOT_MIN: assert property ($fell(serial_data) |-> !serial_data[*8])
    else $error("slot too short");
  AST_END_HIGH: assert property ($fell(o_busy) |-> serial_data)
    else $error("no high end slot");
  AST_DONE_PULSE: assert property (o_burst_done |=> !o_burst_done)
    else $error("done too long");
  AST_DONE_BUSY: assert property (o_burst_done |-> o_busy)
    else $error("done outside burst");
  AST_DONE_LATE: assert property (o_burst_done |-> $past(o_busy, 8))
    else $error("done too early");
  AST_OUT_HOLD: assert property ($changed(o_parallel_out) |->
    o_burst_done || $past(o_burst_done))
    else $error("outputs moved alone");
  // Main scenarios
  COV_DONE: cover property (o_burst_done);
  COV_ALL1: cover property (o_burst_done ##2 o_parallel_out == 5'h1f);
  COV_BURST: cover property ($fell(o_busy));
endmodule

// file: dv/self_timed_single_wire_output_expander_tb.sv
// Bench joining master and receiver across the link
`timescale 1ns/1ps
module self_timed_single_wire_output_expander_tb;
  logic                       i_core_clk = 1'b0;
  logic                       i_rst_b = 1'b0;
  logic                       i_send = 1'b0;
  logic [swx_pkg::DATA_W-1:0] i_data = 5'h00;
  logic [swx_pkg::CNT_W-1:0]  i_bit_cyc = 20'h00019;
  logic                       o_busy;
  logic                       o_burst_done;
  logic [swx_pkg::DATA_W-1:0] o_parallel_out;
  int                         n_errors = 0;
  int                         cmp_count = 0;
  int                         n_done = 0;
  swx_link_if link ();
  swx_master i_swx_master (.i_core_clk(i_core_clk), .i_rst_b(i_rst_b),
    .i_send(i_send), .i_data(i_data), .i_bit_cyc(i_bit_cyc),
    .o_busy(o_busy), .link(link));
  swx_receiver i_swx_receiver (.i_core_clk(i_core_clk), .i_rst_b(i_rst_b),
    .link(link), .o_parallel_out(o_parallel_out),
    .o_burst_done(o_burst_done));
  swx_properties i_swx_properties (.i_core_clk(i_core_clk),
    .i_rst_b(i_rst_b), .serial_data(link.serial_data), .o_busy(o_busy),
    .o_burst_done(o_burst_done), .o_parallel_out(o_parallel_out));
  // Clock and load pulse count
  always #20 i_core_clk = ~i_core_clk;
  always @(posedge i_core_clk) if (o_burst_done === 1'b1) n_done++;
  // Compare and verdict
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic final_report();
    if (n_errors == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic do_reset();
    i_rst_b = 1'b0;
    repeat (8) @(negedge i_core_clk);
    i_rst_b = 1'b1;
  endtask
  task automatic wait_idle();
    for (int t = 0; o_busy !== 1'b0; t++) begin
      if (t > 30000) begin
        n_errors++;
        final_report();
      end
      @(negedge i_core_clk);
    end
  endtask
  // One burst: wire checked mid-slot, then outputs and pulse count
  task automatic send(input logic [4:0] d, input int n);
    logic [8:0] pat;
    int         base;
    pat = {3'b010, d, 1'b1};
    wait_idle();
    base = n_done;
    i_bit_cyc = n[19:0];
    i_data = d;
    i_send = 1'b1;
    @(negedge i_core_clk);
    i_send = 1'b0;
    repeat (n / 2) @(negedge i_core_clk);
    for (int k = 8; k >= 0; k--) begin
      check(link.serial_data, pat[k]);
      repeat (n) @(negedge i_core_clk);
    end
    wait_idle();
    check(n_done - base, 1);
    check(o_parallel_out, d);
  endtask
  task automatic s_order();
    logic [4:0] v[4] = '{5'h10, 5'h01, 5'h15, 5'h0a};
    foreach (v[i]) send(v[i], 25);
  endtask
  task automatic s_rates();
    send(5'h1f, 37);
    send(5'h06, 1000);
  endtask
  task automatic s_hold();
    int base;
    base = n_done;
    repeat (500) @(negedge i_core_clk);
    check(n_done - base, 0);
    check(o_parallel_out, 5'h06);
  endtask
  task automatic s_abort();
    i_data = 5'h1f;
    i_send = 1'b1;
    @(negedge i_core_clk);
    i_send = 1'b0;
    repeat (100) @(negedge i_core_clk);
    do_reset();
    check(o_parallel_out, 5'h00);
    send(5'h1b, 25);
  endtask
  initial begin
    do_reset();
    s_order();
    s_rates();
    s_hold();
    s_abort();
    final_report();
  end
endmodule
